// ===== logic/lineif_pkg.sv
package lineif_pkg;
    // Control path decode of the three-level select pin
    typedef enum logic [1:0] {
        path_hardware,
        path_serial,
        path_parallel
    } control_path_t;
    // Three-level strap values
    typedef enum logic [1:0] {
        level_low,
        level_mid,
        level_high
    } tri_level_t;
    // Parallel host variants
    typedef enum logic [1:0] {
        host_nomux_ds,
        host_nomux_pair,
        host_mux_ds,
        host_mux_pair
    } host_variant_t;
    // Hardware-mode decodes
    typedef enum logic [1:0] {
        loop_remote,
        loop_none,
        loop_analog
    } loop_mode_t;
    typedef enum logic [1:0] {
        jitter_transmit,
        jitter_bypass,
        jitter_receive
    } jitter_pos_t;
    localparam int addr_width = 5;
    localparam int data_width = 8;
    localparam int channels = 8;
    localparam int serial_frame_bits = 16;
    localparam int serial_cmd_bits = 8;
    localparam int serial_dir_bit = 7;
    localparam int ready_wait_cycles = 2;
    localparam int ack_delay_cycles = 2;
endpackage : lineif_pkg

// ===== logic/lineif_host_control_port.sv
`timescale 1ns/1ps
module lineif_host_control_port (
    input wire logic sys_clk,
    input wire logic srst,
    input wire lineif_pkg::tri_level_t control_path_sel,
    input wire logic bus_muxing_sel,
    input wire logic host_style_sel,
    input wire lineif_pkg::tri_level_t jitter_position_sel,
    input wire lineif_pkg::tri_level_t loop_select [lineif_pkg::channels],
    input wire logic edge_polarity_sel,
    input wire logic output_enable,
    input wire logic chip_select_n,
    input wire logic shift_clk,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe_n,
    input wire logic addr_latch,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [lineif_pkg::addr_width-1:0] addr_in,
    input wire logic [lineif_pkg::data_width-1:0] data_in,
    output logic [lineif_pkg::data_width-1:0] data_out,
    output logic data_oe_n,
    output logic ready,
    output logic ack_n,
    input wire logic [2:0] irq_source,
    output logic irq_n_out,
    output logic irq_n_oe_n,
    output logic [lineif_pkg::addr_width-1:0] reg_addr,
    output logic [lineif_pkg::data_width-1:0] reg_wdata,
    output logic reg_write,
    output logic reg_read,
    input wire logic [lineif_pkg::data_width-1:0] reg_rdata,
    output lineif_pkg::control_path_t active_path,
    output lineif_pkg::host_variant_t host_variant,
    output logic line_code_ami,
    output lineif_pkg::jitter_pos_t jitter_position,
    output lineif_pkg::loop_mode_t loop_mode [lineif_pkg::channels],
    output logic line_drivers_off
);
    import lineif_pkg::*;

    logic [2:0] cs_sync, as_sync, rd_sync, wr_sync;
    logic cs_n, as_l, rd_n, wr_n;
    logic [addr_width-1:0] addr_hold;
    logic write_dir;
    logic [1:0] wait_count;
    logic in_access;
    logic serial_busy;

    // Three-stage input filter: change accepted when stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cs_sync <= 3'h7;
            as_sync <= 3'h7;
            rd_sync <= 3'h7;
            wr_sync <= 3'h7;
            cs_n <= 1'b1;
            as_l <= 1'b1;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
        end else begin
            cs_sync <= {cs_sync[1:0], chip_select_n};
            as_sync <= {as_sync[1:0], addr_latch};
            rd_sync <= {rd_sync[1:0], read_strobe_n};
            wr_sync <= {wr_sync[1:0], write_strobe_n};
            if (cs_sync[1] == cs_sync[2]) cs_n <= cs_sync[2];
            if (as_sync[1] == as_sync[2]) as_l <= as_sync[2];
            if (rd_sync[1] == rd_sync[2]) rd_n <= rd_sync[2];
            if (wr_sync[1] == wr_sync[2]) wr_n <= wr_sync[2];
        end
    end

    // Mode decode; straps are static so they are sampled once per clock
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            active_path <= path_hardware;
            host_variant <= host_nomux_ds;
            line_code_ami <= 1'b0;
            jitter_position <= jitter_bypass;
            line_drivers_off <= 1'b1;
        end else begin
            unique case (control_path_sel)
                level_low: active_path <= path_hardware;
                level_mid: active_path <= path_serial;
                default: active_path <= path_parallel;
            endcase
            host_variant <= host_variant_t'({bus_muxing_sel,
                host_style_sel});
            line_code_ami <= host_style_sel;
            unique case (jitter_position_sel)
                level_low: jitter_position <= jitter_transmit;
                level_mid: jitter_position <= jitter_bypass;
                default: jitter_position <= jitter_receive;
            endcase
            line_drivers_off <= !output_enable;
        end
    end

    for (genvar ch = 0; ch < channels; ch++) begin : g_loop
        always_ff @(posedge sys_clk) begin
            if (srst) begin
                loop_mode[ch] <= loop_none;
            end else begin
                unique case (loop_select[ch])
                    level_low: loop_mode[ch] <= loop_remote;
                    level_mid: loop_mode[ch] <= loop_none;
                    default: loop_mode[ch] <= loop_analog;
                endcase
            end
        end
    end

    wire parallel_on = active_path == path_parallel && !cs_n;
    wire muxed = host_variant == host_mux_ds || host_variant == host_mux_pair;
    wire pair_style = host_variant == host_nomux_pair ||
        host_variant == host_mux_pair;
    logic as_l_d, rd_n_d, wr_n_d;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            as_l_d <= 1'b1;
            rd_n_d <= 1'b1;
            wr_n_d <= 1'b1;
        end else begin
            as_l_d <= as_l;
            rd_n_d <= rd_n;
            wr_n_d <= wr_n;
        end
    end
    // Data strobe travels on the write strobe pin; in the data-strobe variants direction is on the read pin
    wire strobe_fall = wr_n_d && !wr_n;
    wire strobe_rise = !wr_n_d && wr_n;
    wire read_fall = rd_n_d && !rd_n;
    wire latch_fall = as_l_d && !as_l;

    // Parallel access engine; the accepted address feeds the register port
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            addr_hold <= '0;
            reg_addr <= '0;
            reg_wdata <= '0;
            reg_write <= 1'b0;
            reg_read <= 1'b0;
            write_dir <= 1'b0;
            in_access <= 1'b0;
        end else begin
            reg_write <= 1'b0;
            reg_read <= 1'b0;
            if (parallel_on && muxed && latch_fall) begin
                addr_hold <= data_in[addr_width-1:0];
            end
            if (parallel_on && !pair_style && strobe_fall) begin
                in_access <= 1'b1;
                write_dir <= !rd_n;
                reg_addr <= muxed ? addr_hold : addr_in;
                reg_read <= rd_n;
            end else if (parallel_on && pair_style && read_fall) begin
                in_access <= 1'b1;
                write_dir <= 1'b0;
                reg_addr <= muxed ? addr_hold : addr_in;
                reg_read <= 1'b1;
            end else if (parallel_on && pair_style && !wr_n && wr_n_d) begin
                in_access <= 1'b1;
                write_dir <= 1'b1;
                reg_addr <= muxed ? addr_hold : addr_in;
            end
            if (parallel_on && strobe_rise && write_dir) begin
                reg_wdata <= data_in;
                reg_write <= 1'b1;
            end
            if (cs_n || (pair_style && rd_n && wr_n) ||
                (!pair_style && wr_n && !strobe_rise)) begin
                in_access <= 1'b0;
            end
        end
    end

    // Short wait count models register access latency
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wait_count <= '0;
        end else if (!in_access) begin
            wait_count <= '0;
        end else if (wait_count != 2'(ready_wait_cycles)) begin
            wait_count <= wait_count + 2'h1;
        end
    end
    wire access_done = in_access && wait_count == 2'(ready_wait_cycles);

    // Read data and handshake on the host side
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            data_out <= '0;
            data_oe_n <= 1'b1;
            ready <= 1'b1;
            ack_n <= 1'b1;
        end else begin
            if (reg_read) data_out <= reg_rdata;
            data_oe_n <= !(parallel_on && in_access && !write_dir);
            ready <= !(pair_style && in_access && !access_done);
            ack_n <= !(!pair_style && access_done);
        end
    end

    // Interrupt: pull low while any source is active, otherwise release
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq_n_oe_n <= 1'b1;
        end else begin
            irq_n_oe_n <= !(|irq_source);
        end
    end
    assign irq_n_out = 1'b0;

    // Serial link logic on the shift clock; chip select resets the frame
    logic [4:0] bit_count;
    logic [7:0] shift_cmd, shift_rd;
    logic serial_write;
    logic [data_width-1:0] rd_capture;
    wire serial_cs_n = chip_select_n || active_path != path_serial;
    logic rise_out, fall_out, rise_oe, fall_oe;

    always_ff @(posedge shift_clk or posedge serial_cs_n) begin
        if (serial_cs_n) begin
            bit_count <= '0;
            shift_cmd <= '0;
        end else begin
            if (bit_count != 5'(serial_frame_bits)) begin
                bit_count <= bit_count + 5'h1;
            end
            shift_cmd <= {shift_cmd[6:0], serial_in};
        end
    end
    wire cmd_done = bit_count >= 5'(serial_cmd_bits);
    always_ff @(posedge shift_clk or posedge serial_cs_n) begin
        if (serial_cs_n) begin
            serial_write <= 1'b0;
        end else if (bit_count == 5'h0) begin
            // Direction is the first bit shifted in, MSB first
            serial_write <= !serial_in;
        end
    end
    // Read data is taken from the register port when the command ends
    assign rd_capture = reg_rdata;
    always_ff @(posedge shift_clk or posedge serial_cs_n) begin
        if (serial_cs_n) begin
            rise_out <= 1'b0;
            rise_oe <= 1'b1;
            shift_rd <= '0;
        end else begin
            if (bit_count == 5'(serial_cmd_bits - 1)) begin
                shift_rd <= rd_capture;
            end else if (cmd_done) begin
                shift_rd <= {shift_rd[6:0], 1'b0};
            end
            rise_oe <= !cmd_done;
            rise_out <= serial_write ? 1'b0 : shift_rd[7];
        end
    end
    always_ff @(negedge shift_clk or posedge serial_cs_n) begin
        if (serial_cs_n) begin
            fall_out <= 1'b0;
            fall_oe <= 1'b1;
        end else begin
            fall_oe <= !cmd_done;
            fall_out <= serial_write ? 1'b0 : shift_rd[7];
        end
    end
    assign serial_out = edge_polarity_sel ? fall_out : rise_out;
    assign serial_out_oe_n = edge_polarity_sel ? fall_oe : rise_oe;
    assign serial_busy = !serial_cs_n;
endmodule : lineif_host_control_port

// ===== bench/serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model (
    output logic shift_clk,
    output logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe_n,
    input wire logic edge_polarity_sel
);
    initial shift_clk = 1'h0;
    initial serial_in = 1'h0;
    // Clock stands low outside frames; sampled opposite the launch edge
    task automatic frame(input logic [15:0] bits, output logic [15:0] so, oe);
        for (int i = 15; i >= 0; i--) begin
            serial_in = bits[i];
            #1;
            if (edge_polarity_sel)
                {so[i], oe[i]} = {serial_out, serial_out_oe_n};
            #2 shift_clk = 1'h1;
            #2;
            if (!edge_polarity_sel)
                {so[i], oe[i]} = {serial_out, serial_out_oe_n};
            #1 shift_clk = 1'h0;
        end
        serial_in = ~serial_in;
    endtask : frame
endmodule : serial_host_model

// ===== bench/lineif_host_control_port_properties.sv
`timescale 1ns/1ps
module lineif_host_control_port_properties (
    input wire logic sys_clk,
    input wire logic srst,
    input wire lineif_pkg::tri_level_t control_path_sel,
    input wire logic bus_muxing_sel,
    input wire logic host_style_sel,
    input wire logic output_enable,
    input wire logic [2:0] irq_source,
    input wire logic irq_n_out,
    input wire logic irq_n_oe_n,
    input wire logic reg_write,
    input wire logic ack_n,
    input wire lineif_pkg::control_path_t active_path,
    input wire lineif_pkg::host_variant_t host_variant,
    input wire logic line_code_ami,
    input wire logic line_drivers_off
);
    import lineif_pkg::*;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    // Three steady cycles leave room for the output register
    sequence irq_held;
        (|irq_source) [*3];
    endsequence
    serial_path_a: assert property (
        control_path_sel == level_mid |=> active_path == path_serial)
        else $error("serial path");
    host_variant_a: assert property (
        control_path_sel == level_high |=> host_variant ==
        {$past(bus_muxing_sel), $past(host_style_sel)}) else $error("variant");
    line_code_a: assert property (
        !srst && control_path_sel == level_low |=>
        line_code_ami == $past(host_style_sel)) else $error("line code");
    drivers_off_a: assert property (
        !srst |=> line_drivers_off == !$past(output_enable)) else $error("oe");
    irq_pull_a: assert property (
        irq_held |-> !irq_n_oe_n && !irq_n_out) else $error("irq low");
    irq_release_a: assert property (
        (irq_source == 3'h0) [*3] |-> irq_n_oe_n) else $error("irq idle");
    write_pulse_a: assert property (
        reg_write |-> active_path == path_parallel ##1 !reg_write)
        else $error("write pulse");
    ack_style_a: assert property (
        $fell(ack_n) |-> active_path == path_parallel && !host_variant[0])
        else $error("ack style");
endmodule : lineif_host_control_port_properties
bind lineif_host_control_port lineif_host_control_port_properties props (
    .sys_clk, .srst, .control_path_sel, .bus_muxing_sel, .host_style_sel,
    .output_enable, .irq_source, .irq_n_out, .irq_n_oe_n, .reg_write, .ack_n,
    .active_path, .host_variant, .line_code_ami, .line_drivers_off);

// ===== bench/lineif_host_control_port_bench.sv
`timescale 1ns/1ps
module lineif_host_control_port_bench;
    import lineif_pkg::*;
    typedef struct packed {
        logic [1:0] cp, js, lp;
        logic mux, sty, oe;
        logic [1:0] ap, hv, jp, lm;
    } row_t;
    // Straps path, jitter, loop, mux, style, enable; then expected decodes
    row_t rows [7] = '{17'h00100, 17'h02a05, 17'h0510a, 17'h12980,
        17'h12b90, 17'h12da0, 17'h12fb0};
    row_t r;
    logic sys_clk = 1'h0, srst = 1'h1;
    tri_level_t control_path_sel = level_low, jitter_position_sel = level_mid;
    tri_level_t loop_select [channels] = '{default: level_mid};
    logic bus_muxing_sel = 1'h0, host_style_sel = 1'h0, output_enable = 1'h1;
    logic edge_polarity_sel = 1'h0, chip_select_n = 1'h1, addr_latch = 1'h1;
    logic read_strobe_n = 1'h1, write_strobe_n = 1'h1;
    logic [4:0] addr_in = 5'h00, reg_addr;
    logic [7:0] data_in = 8'h00, reg_rdata = 8'h3c, data_out, reg_wdata;
    logic [2:0] irq_source = 3'h0;
    logic shift_clk, serial_in, serial_out, serial_out_oe_n, data_oe_n, ready;
    logic ack_n, irq_n_out, irq_n_oe_n, reg_write, reg_read;
    logic line_code_ami, line_drivers_off;
    control_path_t active_path;
    host_variant_t host_variant;
    jitter_pos_t jitter_position;
    loop_mode_t loop_mode [channels];
    int failures = 0, n_compared = 0, n_writes = 0;
    logic [15:0] so, oe;
    lineif_host_control_port uut (.sys_clk, .srst, .control_path_sel,
        .bus_muxing_sel, .host_style_sel, .jitter_position_sel, .loop_select,
        .edge_polarity_sel, .output_enable, .chip_select_n, .shift_clk,
        .serial_in, .serial_out, .serial_out_oe_n, .addr_latch, .read_strobe_n,
        .write_strobe_n, .addr_in, .data_in, .data_out, .data_oe_n, .ready,
        .ack_n, .irq_source, .irq_n_out, .irq_n_oe_n, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .active_path, .host_variant,
        .line_code_ami, .jitter_position, .loop_mode, .line_drivers_off);
    serial_host_model host (.shift_clk, .serial_in, .serial_out,
        .serial_out_oe_n, .edge_polarity_sel);
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (reg_write === 1'h1) n_writes++;
    task automatic check(input string what, input logic [15:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    task automatic conclude;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    // Pin steps are six cycles apart: the pin filter passes a change four cycles after it
    task automatic access(input logic rd, input logic [4:0] a, input [7:0] d);
        tick(1);
        chip_select_n <= 1'h0;
        addr_in <= a;
        data_in <= bus_muxing_sel ? {3'h7, a} : d;
        read_strobe_n <= host_style_sel | rd;
        tick(6);
        addr_latch <= ~bus_muxing_sel;
        tick(6);
        data_in <= d;
        tick(2);
        if (rd & host_style_sel) read_strobe_n <= 1'h0;
        else write_strobe_n <= 1'h0;
        @(negedge sys_clk);
        // Ready idles high, so first see the wait state begin
        repeat (8) if (host_style_sel && ready === 1'h1) @(negedge sys_clk);
        repeat (20) if ((host_style_sel ? ready : !ack_n) !== 1'h1)
            @(negedge sys_clk);
        check("address", reg_addr, a);
        check("handshake", host_style_sel ? ready : ack_n, host_style_sel);
        if (rd) check("read", {data_oe_n, data_out}, reg_rdata);
        tick(6);
        write_strobe_n <= 1'h1;
        read_strobe_n <= host_style_sel | rd;
        repeat (12) if (!rd && reg_write !== 1'h1) @(negedge sys_clk);
        if (!rd) check("write", reg_wdata, d);
        tick(2);
        chip_select_n <= 1'h1;
        addr_latch <= 1'h1;
        read_strobe_n <= 1'h1;
        tick(6);
    endtask : access
    initial begin
        tick(2);
        @(negedge sys_clk);
        check("reset", {ready, ack_n, data_oe_n, line_drivers_off}, 4'hf);
        tick(1);
        srst <= 1'h0;
        foreach (rows[i]) begin
            r = rows[i];
            tick(1);
            control_path_sel <= tri_level_t'(r.cp);
            jitter_position_sel <= tri_level_t'(r.js);
            loop_select <= '{default: tri_level_t'(r.lp)};
            bus_muxing_sel <= r.mux;
            host_style_sel <= r.sty;
            output_enable <= r.oe;
            tick(4);
            @(negedge sys_clk);
            check("path", active_path, r.ap);
            check("drivers off", line_drivers_off, !r.oe);
            if (r.cp == 2'h2) check("variant", host_variant, r.hv);
            if (r.cp == 2'h0) begin
                check("line code", line_code_ami, r.sty);
                check("jitter", jitter_position, r.jp);
                foreach (loop_mode[c])
                    check("loop", loop_mode[c], r.lm);
            end
        end
        $display("strap table done");
        for (int m = 0; m < 2; m++) begin
            tick(1);
            bus_muxing_sel <= m[0];
            host_style_sel <= m[0];
            access(1'h0, m[0] ? 5'h15 : 5'h1f, 8'ha5);
            access(1'h1, m[0] ? 5'h0a : 5'h00, 8'h00);
        end
        $display("parallel accesses done");
        write_strobe_n <= 1'h0;
        tick(8);
        write_strobe_n <= 1'h1;
        tick(8);
        check("write count", n_writes, 16'h0002);
        $display("refused strobe done");
        for (int k = 0; k < 3; k++) begin
            irq_source <= 3'h1 << k;
            tick(5);
            @(negedge sys_clk);
            check("irq", {irq_n_oe_n, irq_n_out}, 2'h0);
            tick(1);
            irq_source <= 3'h0;
            tick(5);
        end
        $display("interrupts done");
        for (int p = 0; p < 2; p++) begin
            control_path_sel <= level_mid;
            edge_polarity_sel <= p[0];
            chip_select_n <= 1'h0;
            tick(6);
            host.frame(16'h0aa5, so, oe);
            check("write oe", oe, 16'hff00);
            check("write out", so & 16'h00ff, 16'h0000);
            tick(1);
            chip_select_n <= 1'h1;
            tick(6);
            chip_select_n <= 1'h0;
            tick(6);
            host.frame(16'h8a00, so, oe);
            check("read oe", oe, 16'hff00);
            check("read out", so & 16'h00ff, reg_rdata);
            tick(1);
            chip_select_n <= 1'h1;
            tick(6);
        end
        $display("serial frames done");
        conclude();
    end
    // About twenty-five times the expected run
    initial begin
        #50000;
        failures++;
        conclude();
    end
endmodule : lineif_host_control_port_bench
